//--- txcs_regs.vh
// register offsets, field positions, reset values and timing counts of the tx clock select block
`ifndef TXCS_REGS_VH
`define TXCS_REGS_VH
`define TXCS_A_CTRL        4'h0
`define TXCS_A_STATUS      4'h1
`define TXCS_A_INT_STAT    4'h2
`define TXCS_A_INT_MASK    4'h3
`define TXCS_A_LOG         4'h4
`define TXCS_A_DIV         4'h5
`define TXCS_CTRL_TXM_LO   0
`define TXCS_CTRL_RXM_LO   2
`define TXCS_CTRL_MUX_LO   4
`define TXCS_CTRL_STNREF   6
`define TXCS_CTRL_RST      8'h01
`define TXCS_DIV_RST       8'h20
`define TXCS_TXM_EXT       2'h0
`define TXCS_TXM_INT       2'h1
`define TXCS_TXM_RXREF     2'h2
`define TXCS_RXM_SAT       2'h0
`define TXCS_RXM_STN       2'h1
`define TXCS_RXM_INT       2'h2
`define TXCS_RXM_DCE       2'h3
`define TXCS_MUX_DATA      2'h0
`define TXCS_MUX_AUDIO     2'h1
`define TXCS_MUX_AUDDATA   2'h2
`define TXCS_IRQ_MARGINAL  0
`define TXCS_IRQ_EXTFAIL   1
`define TXCS_IRQ_EXTOK     2
`define TXCS_CLK_PERIOD_NS 10
`define TXCS_EXT_TMO_NS    10000
`define TXCS_EXT_TMO_CYC   (`TXCS_EXT_TMO_NS / `TXCS_CLK_PERIOD_NS)
`define TXCS_EXT_OK_EDGES  3'h4
`endif

//--- txcs_top.v
// transmit clock source selection, data phase monitor and audio multiplexer
`timescale 1ns/1ns
`default_nettype none
`include "txcs_regs.vh"
// Notes on behaviour
// - compare incoming data transitions against the active sampling edge, always
// - a violation on the active edge moves sampling to the opposite edge
// - marginal warning is a one-cycle pulse per switch, counted in a log
// - no control exists that disables the marginal warning
// - external mode uses the clock input, internal backup when it fails
// - internal clock is driven on a dedicated output and used internally
// - internal clock comes from internal reference, or station clock when selected and present
// - receive-referenced mode follows the receive output clock, except with receive set to dce
// - failed receive clock: receive backup clock also times transmit when receive-referenced outside dce
// - receive-referenced timing outside dce sends at the receive output clock rate, so tx and rx rates match
// - receive-referenced with receive set to dce: station clock if present, else internal
// - audio-only mode builds a 64k stream from two 32k audio ports
// - audio-only mode forces transmit internal and receive satellite clocking
// - audio-plus-data builds 128k from both audio ports and main data

// three-stage synchroniser; output changes only when stages two and three agree
module txcs_sync3 #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    integer i;

    // first stage feeds only the second
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= {W{1'b0}};
            s2_r <= {W{1'b0}};
            s3_r <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    q[i] <= s3_r[i];
                end
            end
        end
    end
endmodule // txcs_sync3

module txcs_top (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       ext_clk_in,
    input  wire       tx_data_in,
    input  wire       rx_sat_clk,
    input  wire       stn_clk,
    input  wire       rx_backup_clk,
    input  wire       stn_present,
    input  wire       rx_sel_fail,
    input  wire       ovh_octet_ok,
    input  wire       audio_a_bit,
    input  wire       audio_b_bit,
    output wire       int_tx_clk_out,
    output reg        tx_bit,
    output reg        tx_bit_valid,
    output reg        data_marginal,
    output wire [1:0] rx_mode_eff,
    output wire       irq
);
    // software registers
    reg  [7:0]  ctrl_r;
    reg  [7:0]  div_r;
    reg  [2:0]  int_stat_r;
    reg  [2:0]  int_mask_r;
    reg  [7:0]  log_r;
    // clock selection state
    reg  [7:0]  div_cnt_r;
    reg         int_clk_r;
    reg         ext_fail_r;
    reg  [15:0] tmo_cnt_r;
    reg  [2:0]  ok_cnt_r;
    reg         txclk_d_r;
    reg         data_d_r;
    reg         edge_fall_r;
    reg  [1:0]  phase_r;
    reg         mux_err_r;
    wire [4:0]  pin_f;
    wire        ext_f;
    wire        data_f;
    wire        sat_f;
    wire        stn_f;
    wire        bkp_f;
    wire [1:0]  txm_user;
    wire [1:0]  rxm_user;
    wire [1:0]  mux_mode;
    wire        audio_only;
    wire [1:0]  txm_eff;
    wire        ref_tick;
    wire        stn_prev;
    reg         stn_d_r;
    reg         ext_d_r;
    reg         rx_out_clk;
    reg         tx_clk_sel;
    wire        tx_rise;
    wire        tx_fall;
    wire        samp_edge;
    wire        data_chg;
    wire        violation;
    wire        ext_rise;
    wire        ext_timeout;
    wire        ext_restore;
    wire        rd_int;
    wire [2:0]  ev;

    wire bkp_in_w = rx_backup_clk;

    // the ext clock, data, satellite, station and backup clock pins pass the three-stage synchroniser
    txcs_sync3 #(
        .W (5)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({bkp_in_w, stn_clk, rx_sat_clk, tx_data_in, ext_clk_in}),
        .q     (pin_f)
    );
    assign ext_f  = pin_f[0];
    assign data_f = pin_f[1];
    assign sat_f  = pin_f[2];
    assign stn_f  = pin_f[3];
    assign bkp_f  = pin_f[4];

    assign txm_user   = ctrl_r[`TXCS_CTRL_TXM_LO+1:`TXCS_CTRL_TXM_LO];
    assign rxm_user   = ctrl_r[`TXCS_CTRL_RXM_LO+1:`TXCS_CTRL_RXM_LO];
    assign mux_mode   = ctrl_r[`TXCS_CTRL_MUX_LO+1:`TXCS_CTRL_MUX_LO];
    assign audio_only = (mux_mode == `TXCS_MUX_AUDIO);
    // audio-only overrides the user clocking; audio+data keeps it
    assign txm_eff     = audio_only ? `TXCS_TXM_INT : txm_user;
    assign rx_mode_eff = audio_only ? `TXCS_RXM_SAT : rxm_user;

    // reference tick: every cycle from internal reference, or each rising station clock edge
    assign stn_prev = stn_d_r;
    assign ref_tick = (ctrl_r[`TXCS_CTRL_STNREF] && stn_present) ?
                      (stn_f && !stn_prev) : 1'b1;

    // internal clock divider; output pin carries the same clock used inside
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= 8'h00;
            int_clk_r <= 1'b0;
            stn_d_r   <= 1'b0;
            ext_d_r   <= 1'b0;
        end else begin
            stn_d_r <= stn_f;
            ext_d_r <= ext_f;
            if (ref_tick) begin
                if (div_cnt_r >= div_r) begin
                    div_cnt_r <= 8'h00;
                    int_clk_r <= ~int_clk_r;
                end else begin
                    div_cnt_r <= div_cnt_r + 8'h01;
                end
            end
        end
    end
    assign int_tx_clk_out = int_clk_r;

    // external clock watchdog on the internal reference
    assign ext_rise    = ext_f && !ext_d_r;
    assign ext_timeout = !ext_fail_r && (tmo_cnt_r >= `TXCS_EXT_TMO_CYC - 1) && !ext_rise;
    assign ext_restore = ext_fail_r && ext_rise && (ok_cnt_r == `TXCS_EXT_OK_EDGES - 3'h1);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tmo_cnt_r  <= 16'h0000;
            ok_cnt_r   <= 3'h0;
            ext_fail_r <= 1'b1;
        end else begin
            if (ext_rise) begin
                tmo_cnt_r <= 16'h0000;
            end else if (tmo_cnt_r < `TXCS_EXT_TMO_CYC - 1) begin
                tmo_cnt_r <= tmo_cnt_r + 16'h0001;
            end
            if (ext_timeout) begin
                ext_fail_r <= 1'b1;
                ok_cnt_r   <= 3'h0;
            end else if (ext_restore) begin
                ext_fail_r <= 1'b0;
                ok_cnt_r   <= 3'h0;
            end else if (ext_fail_r && ext_rise) begin
                ok_cnt_r <= ok_cnt_r + 3'h1;
            end else if (ext_fail_r && tmo_cnt_r >= `TXCS_EXT_TMO_CYC - 1) begin
                ok_cnt_r <= 3'h0; // edges must resume steadily, a gap restarts the count
            end
        end
    end

    // receive output clock and the transmit clock mux; the tx path only follows
    // edges of the chosen clock, so tx and rx rates need no relation unless tx is receive-referenced
    always @* begin
        case (rx_mode_eff)
            `TXCS_RXM_SAT: rx_out_clk = sat_f;
            `TXCS_RXM_STN: rx_out_clk = stn_f;
            `TXCS_RXM_INT: rx_out_clk = int_clk_r;
            default:       rx_out_clk = int_clk_r;
        endcase
        if (rx_sel_fail) begin
            rx_out_clk = bkp_f;
        end
        case (txm_eff)
            `TXCS_TXM_EXT:   tx_clk_sel = ext_fail_r ? int_clk_r : ext_f;
            `TXCS_TXM_INT:   tx_clk_sel = int_clk_r;
            `TXCS_TXM_RXREF: begin
                if (rx_mode_eff == `TXCS_RXM_DCE) begin
                    tx_clk_sel = stn_present ? stn_f : int_clk_r;
                end else begin
                    tx_clk_sel = rx_out_clk;
                end
            end
            default:         tx_clk_sel = int_clk_r;
        endcase
    end

    assign tx_rise   = tx_clk_sel && !txclk_d_r;
    assign tx_fall   = !tx_clk_sel && txclk_d_r;
    assign samp_edge = edge_fall_r ? tx_fall : tx_rise;
    assign data_chg  = data_f != data_d_r;
    // data moving in the very cycle it is sampled is a phase violation
    assign violation = samp_edge && data_chg;

    // sampling edge control, marginal pulse and bit stream assembly
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txclk_d_r     <= 1'b0;
            data_d_r      <= 1'b0;
            edge_fall_r   <= 1'b0;
            data_marginal <= 1'b0;
            tx_bit        <= 1'b0;
            tx_bit_valid  <= 1'b0;
            phase_r       <= 2'h0;
            mux_err_r     <= 1'b0;
        end else begin
            txclk_d_r     <= tx_clk_sel;
            data_d_r      <= data_f;
            data_marginal <= violation;
            tx_bit_valid  <= samp_edge;
            mux_err_r     <= (mux_mode != `TXCS_MUX_DATA) && !ovh_octet_ok;
            if (violation) begin
                edge_fall_r <= ~edge_fall_r;
            end
            if (samp_edge) begin
                phase_r <= phase_r + 2'h1;
                case (mux_mode)
                    `TXCS_MUX_AUDIO:   tx_bit <= phase_r[0] ? audio_b_bit : audio_a_bit;
                    `TXCS_MUX_AUDDATA: begin
                        // a, data, b, data: half audio, half main data
                        case (phase_r)
                            2'h0:    tx_bit <= audio_a_bit;
                            2'h2:    tx_bit <= audio_b_bit;
                            default: tx_bit <= data_d_r;
                        endcase
                    end
                    default:           tx_bit <= data_d_r;
                endcase
            end
        end
    end

    // register port; event set wins over read clear
    assign ev     = {ext_restore, ext_timeout, violation};
    assign rd_int = reg_rd && (reg_addr == `TXCS_A_INT_STAT);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r     <= `TXCS_CTRL_RST;
            div_r      <= `TXCS_DIV_RST;
            int_stat_r <= 3'h0;
            int_mask_r <= 3'h0;
            log_r      <= 8'h00;
            reg_rdata  <= 8'h00;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `TXCS_A_CTRL:     ctrl_r <= {1'b0, reg_wdata[6:0]};
                    `TXCS_A_INT_MASK: int_mask_r <= reg_wdata[2:0];
                    `TXCS_A_DIV:      div_r <= reg_wdata;
                    default:          ;
                endcase
            end
            int_stat_r <= (rd_int ? 3'h0 : int_stat_r) | ev;
            // saturating log of edge switches; writing the log clears it unless a switch counts in the same cycle
            if (violation && log_r != 8'hff) begin
                log_r <= log_r + 8'h01;
            end else if (reg_wr && reg_addr == `TXCS_A_LOG) begin
                log_r <= 8'h00;
            end
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `TXCS_A_CTRL:     reg_rdata <= ctrl_r;
                    `TXCS_A_STATUS:   reg_rdata <= {mux_err_r, stn_present, rx_sel_fail,
                                                    edge_fall_r, ext_fail_r, 1'b0, txm_eff};
                    `TXCS_A_INT_STAT: reg_rdata <= {5'h00, int_stat_r};
                    `TXCS_A_INT_MASK: reg_rdata <= {5'h00, int_mask_r};
                    `TXCS_A_LOG:      reg_rdata <= log_r;
                    `TXCS_A_DIV:      reg_rdata <= div_r;
                    default:          reg_rdata <= 8'h00;
                endcase
            end
        end
    end
    // a set mask bit silences its status bit; mask resets clear so every event is heard
    assign irq = |(int_stat_r & ~int_mask_r);
endmodule // txcs_top
`default_nettype wire

//--- txcs_chk.sv
// concurrent checks on the tx clock select top ports
`timescale 1ns/1ns
`default_nettype none
`include "txcs_regs.vh"
module txcs_chk (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       rx_sel_fail,
    input wire logic       int_tx_clk_out,
    input wire logic       tx_bit,
    input wire logic       tx_bit_valid,
    input wire logic       data_marginal,
    input wire logic [1:0] rx_mode_eff
);
    logic [7:0] div_r, run_r, wd_r;
    logic [1:0] seen_r;
    logic       ck_r;
    wire        tog = int_tx_clk_out != ck_r;
    wire        ctl = reg_wr && reg_addr == `TXCS_A_CTRL;
    // shadow divider; after a write two toggles pass before the period is trusted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r  <= `TXCS_DIV_RST;
            run_r  <= 8'h00;
            wd_r   <= 8'h00;
            seen_r <= 2'h0;
            ck_r   <= 1'b0;
        end else begin
            wd_r  <= reg_wdata;
            ck_r  <= int_tx_clk_out;
            run_r <= tog ? 8'h00 : run_r + 8'h01;
            if (ctl || (reg_wr && reg_addr == `TXCS_A_DIV)) begin
                seen_r <= 2'h0;
            end else if (tog && seen_r != 2'h3) begin
                seen_r <= seen_r + 2'h1;
            end
            if (reg_wr && reg_addr == `TXCS_A_DIV) begin
                div_r <= reg_wdata;
            end
        end
    end
    a_marginal_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        data_marginal |=> !data_marginal) else $error("marginal pulse too long");
    a_marginal_valid: assert property (@(posedge clk) disable iff (!rst_n)
        data_marginal |-> tx_bit_valid) else $error("marginal without sample");
    a_valid_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        tx_bit_valid |=> !tx_bit_valid) else $error("valid pulse too long");
    a_bit_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !tx_bit_valid |-> $stable(tx_bit)) else $error("bit moved without valid");
    a_audio_rx_sat: assert property (@(posedge clk) disable iff (!rst_n)
        ctl && reg_wdata[5:4] == `TXCS_MUX_AUDIO |=> rx_mode_eff == `TXCS_RXM_SAT)
        else $error("audio mode did not force rx clock");
    a_rx_mode_follow: assert property (@(posedge clk) disable iff (!rst_n)
        ctl && reg_wdata[5:4] != `TXCS_MUX_AUDIO && !rx_sel_fail
        |=> rx_mode_eff == wd_r[3:2]) else $error("rx mode not taken");
    a_int_clk_period: assert property (@(posedge clk) disable iff (!rst_n)
        tog && seen_r >= 2'h2 |-> run_r == div_r) else $error("int clock period wrong");
    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 8'h00) else $error("read data outside read slot");
endmodule // txcs_chk
bind txcs_top txcs_chk txcs_chk_inst (.*);
`default_nettype wire

//--- txcs_far_end.sv
// far-end terrestrial equipment: tx clock and data, phase fault on command
`timescale 1ns/1ns
`default_nettype none
module txcs_far_end (
    input  wire logic clk,
    input  wire logic run,
    input  wire logic skew,
    output var  logic ext_clk_in,
    output var  logic tx_data_in,
    output var  logic push,
    output var  logic pushed_bit
);
    int seed = 15196;
    int cnt  = 0;
    initial {ext_clk_in, tx_data_in, push, pushed_bit} = 4'h0;
    // clock stands still while run is low; skew moves data onto the rising edge
    always @(posedge clk) begin
        push <= 1'b0;
        cnt  <= run ? (cnt + 1) % 8 : cnt;
        if (run && cnt == 7) begin
            ext_clk_in <= !ext_clk_in;
            push       <= ext_clk_in == skew;
            pushed_bit <= tx_data_in;
            if (ext_clk_in != skew) tx_data_in <= 1'($random(seed));
        end
    end
endmodule // txcs_far_end
`default_nettype wire

//--- txcs_bench.sv
// self-checking bench for the tx clock select block
`timescale 1ns/1ns
`default_nettype none
`include "txcs_regs.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module txcs_bench;
    logic       clk, rst_n, reg_wr, reg_rd, ext_clk_in, tx_data_in, rx_sat_clk, stn_clk;
    logic       rx_backup_clk, stn_present, rx_sel_fail, ovh_octet_ok, audio_a_bit;
    logic       audio_b_bit, int_tx_clk_out, tx_bit, tx_bit_valid, data_marginal, irq;
    logic       run, skew, push, pushed_bit, last, e;
    logic [1:0] rx_mode_eff;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic       q[$];
    int         error_cnt = 0;
    int         n_checks = 0;
    int         seed = 15196;
    int         mode, nm, nv, ck_n, dv, n;
    int         per[4] = '{14, 22, 30, 0};
    logic [1:0] rxm[4] = '{`TXCS_RXM_SAT, `TXCS_RXM_STN, `TXCS_RXM_SAT, `TXCS_RXM_DCE};
    logic       rxf[4] = '{0, 0, 1, 0};
    txcs_top txcs_top_inst (.*);
    txcs_far_end txcs_far_end_inst (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // receive clocks at unrelated rates, and the reference stream model
    always @(posedge clk) begin
        ck_n++;
        rx_sat_clk    <= ck_n % 14 < 7;
        stn_clk       <= ck_n % 22 < 11;
        rx_backup_clk <= ck_n % 30 < 15;
        if (push) q.push_back(pushed_bit);
        nm += data_marginal === 1'b1;
        if (tx_bit_valid === 1'b1) begin
            nv++;
            if (mode == 1) begin
                e = q.size() ? q.pop_front() : 1'bx;
                `CHK("stream", e, tx_bit)
            end
            if (mode == 2) `CHK("audio", !last, tx_bit)
            if (mode == 3) mode = 2;
            last = tx_bit;
        end
    end
    task automatic test_done();
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    // poll until the external clock is declared good again
    task automatic wait_ok();
        for (int i = 0; i < 200; i++) begin
            rd(`TXCS_A_INT_STAT);
            if (d[`TXCS_IRQ_EXTOK]) return;
        end
        error_cnt++;
        test_done();
    endtask
    // drop bits already in flight so the model restarts on an edge boundary
    task automatic flush();
        for (int i = 0; i < 40 && push !== 1'b1; i++) @(posedge clk);
        if (push !== 1'b1) begin
            error_cnt++;
            test_done();
        end
        repeat (8) @(posedge clk);
        q.delete();
    endtask
    initial begin
        {rst_n, reg_wr, reg_rd, run, skew, stn_present, rx_sel_fail} = '0;
        {audio_a_bit, audio_b_bit, reg_addr, reg_wdata} = '0;
        ovh_octet_ok  = 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(`TXCS_A_CTRL);
        `CHK("ctrl", `TXCS_CTRL_RST, d)
        rd(`TXCS_A_DIV);
        `CHK("div", `TXCS_DIV_RST, d)
        rd(4'hf);
        `CHK("unmapped", 8'h00, d)
        wr(`TXCS_A_CTRL, 8'hc5);
        rd(`TXCS_A_CTRL);
        `CHK("ctrl rw", 8'h45, d)
        dv = 1 + ($random(seed) & 7);
        per[3] = 2 * (dv + 1);
        wr(`TXCS_A_DIV, 8'(dv));
        wr(`TXCS_A_CTRL, {6'h00, `TXCS_TXM_INT});
        repeat (60) @(posedge clk);
        n = nv;
        repeat (8 * per[3]) @(posedge clk);
        `CHK("int edges", 8, nv - n)
        wr(`TXCS_A_CTRL, {6'h00, `TXCS_TXM_EXT});
        run <= 1'b1;
        wait_ok();
        flush();
        mode = 1;
        repeat (320) @(posedge clk);
        mode = 0;
        rd(`TXCS_A_STATUS);
        `CHK("ext used", {1'b0, `TXCS_TXM_EXT}, d[3:0])
        run <= 1'b0;
        repeat (1100) @(posedge clk);
        rd(`TXCS_A_STATUS);
        `CHK("backup", {2'b10, `TXCS_TXM_EXT}, d[3:0])
        `CHK("irq", 1'b1, irq)
        wr(`TXCS_A_INT_MASK, 8'h02);
        @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        rd(`TXCS_A_INT_STAT);
        `CHK("int stat", 8'h02, d)
        wr(`TXCS_A_INT_MASK, 8'h00);
        run <= 1'b1;
        wait_ok();
        flush();
        wr(`TXCS_A_LOG, 8'h00);
        // a phase fault, then its removal, each must move the sampling edge once
        for (int k = 1; k <= 2; k++) begin
            n = nm;
            skew <= k[0];
            repeat (200) @(posedge clk);
            `CHK("switches", 1, nm - n)
            rd(`TXCS_A_LOG);
            `CHK("log", k, d)
            rd(`TXCS_A_STATUS);
            `CHK("edge", k[0], d[4])
            flush();
            mode = 1;
            repeat (128) @(posedge clk);
            mode = 0;
        end
        run <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            rx_sel_fail <= rxf[k];
            wr(`TXCS_A_CTRL, {4'h0, rxm[k], `TXCS_TXM_RXREF});
            repeat (60) @(posedge clk);
            `CHK("rx mode", rxm[k], rx_mode_eff)
            n = nv;
            repeat (20 * per[k]) @(posedge clk);
            `CHK("rx ref edges", 20, nv - n)
        end
        rx_sel_fail  <= 1'b0;
        ovh_octet_ok <= 1'b0;
        audio_a_bit  <= 1'b1;
        wr(`TXCS_A_CTRL, {2'h0, `TXCS_MUX_AUDIO, `TXCS_RXM_DCE, `TXCS_TXM_EXT});
        @(posedge clk);
        `CHK("forced rx", `TXCS_RXM_SAT, rx_mode_eff)
        rd(`TXCS_A_STATUS);
        `CHK("forced tx", {4'b1010, `TXCS_TXM_INT}, {d[7], d[4:0]})
        mode = 3;
        repeat (120) @(posedge clk);
        mode = 0;
        audio_a_bit <= !tx_data_in;
        audio_b_bit <= !tx_data_in;
        wr(`TXCS_A_CTRL, {2'h0, `TXCS_MUX_AUDDATA, `TXCS_RXM_STN, `TXCS_TXM_INT});
        @(posedge clk);
        `CHK("aud data rx", `TXCS_RXM_STN, rx_mode_eff)
        mode = 3;
        repeat (120) @(posedge clk);
        mode = 0;
        test_done();
    end
endmodule // txcs_bench
`default_nettype wire
